// *** icf_defs.vh ***
// Command codes, field positions, reset values and timing counts for the input counter block
`ifndef ICF_DEFS_VH
`define ICF_DEFS_VH
`define ICF_CMD_EDGE 8'h2c
`define ICF_CMD_READ 8'h2f
`define ICF_CMD_ENABLE 8'h28
`define ICF_CMD_RELOAD 8'h29
`define ICF_CMD_HIGH_BASE 8'h30
`define ICF_CMD_LOW_BASE 8'h38
`define ICF_CMD_RVAL_BASE 8'h40
`define ICF_RESERVED_OK 8'h00
`define ICF_CHAN_LSB 0
`define ICF_CHAN_MSB 2
`define ICF_SAMPLE_TIME_MS 5
`define ICF_CLOCK_MHZ 100
`define ICF_TICK_CYCLES (`ICF_SAMPLE_TIME_MS * 1000 * `ICF_CLOCK_MHZ)
`define ICF_COUNT_RESET 16'h0000
`define ICF_SAMPLES_RESET 16'h0000
`define ICF_EDGE_RESET 8'h00
`define ICF_ENABLE_RESET 8'h00
`endif

// *** icf_filter.v ***
// Per-channel debounce filter with separate high and low qualification counts
`timescale 1ns/10ps
`include "icf_defs.vh"
module icf_filter (
  input wire clock,
  input wire sys_rst,
  input wire tick,
  input wire raw_level,
  input wire [15:0] high_samples,
  input wire [15:0] low_samples,
  output reg filtered_q
);
  reg [15:0] run_q;
  wire [15:0] need;
  // A count of zero passes the level on the next tick
  assign need = raw_level ? high_samples : low_samples;
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_q <= 16'h0000;
      filtered_q <= 1'b0;
    end
    else if (tick)
    begin
      if (raw_level == filtered_q)
        run_q <= 16'h0000;
      else if (run_q + 16'h0001 >= need)
      begin
        filtered_q <= raw_level;
        run_q <= 16'h0000;
      end
      else
        run_q <= run_q + 16'h0001;
    end
  end
endmodule // icf_filter

// *** icf_counter_block.v ***
// Eight filtered input counters configured through a four-byte command mailbox
// What this block does
// - Command 2C: low byte bit n set counts falling edges, clear counts rising.
// - Every reply carries the eight present input levels in the top byte.
// - Every reply echoes the executed command code in byte 2.
// - Counter read returns count high byte in byte 1, low byte in byte 0.
// - Codes 30-37 set high sample counts, 38-3F low counts, per channel.
// - Sample count is 256 times byte 1 plus byte 0, times 5 ms.
// - Levels shorter than the qualification period are dropped as noise.
// - Codes 40-47 store a 16-bit counter reset value per channel.
// - A reset-value command does nothing to a disabled counter.
// - Command 28 enables counter n when low byte bit n is set.
// - Command 29 reloads counters whose bit is set with their reset value.
`timescale 1ns/10ps
`include "icf_defs.vh"
module icf_counter_block #(
  parameter CHANNELS = 8,
  parameter TICK_CYCLES = `ICF_TICK_CYCLES
) (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] isolated_input,
  input wire cmd_valid,
  input wire [7:0] host_param_low_byte,
  input wire [7:0] host_param_high_byte,
  input wire [7:0] host_command_byte,
  input wire [7:0] host_reserved_byte,
  output reg reply_valid_q,
  output reg [7:0] reply_low_byte_q,
  output reg [7:0] reply_high_byte_q,
  output reg [7:0] reply_echo_byte_q,
  output reg [7:0] reply_input_levels_q,
  output reg [7:0] filtered_levels_q
);
  // =====================================================
  // Input synchronisers
  reg [7:0] s1_q, s2_q, s3_q, stable_q;
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
      stable_q <= 8'h00;
    end
    else
    begin
      s1_q <= isolated_input;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
    end
  end

  // =====================================================
  // 5 ms sampling tick
  // Free-running, so a new level may wait up to one period for its first sample
  reg [31:0] tick_cnt_q;
  reg tick_q;
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q >= TICK_CYCLES - 1)
    begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  // =====================================================
  // Decode helpers
  // Codes come in groups of eight, one per channel
  function in_group;
    input [7:0] code;
    input [7:0] base;
    begin
      in_group = (code[7:3] == base[7:3]);
    end
  endfunction

  function edge_hit;
    input fall_sel;
    input prev_level;
    input now_level;
    begin
      edge_hit = fall_sel ? (prev_level & ~now_level) : (~prev_level & now_level);
    end
  endfunction

  // =====================================================
  // Configuration state
  reg [15:0] high_samples_q [0:7];
  reg [15:0] low_samples_q [0:7];
  reg [15:0] reset_value_q [0:7];
  reg [15:0] count_q [0:7];
  reg [7:0] edge_sel_q;
  reg [7:0] enable_q;
  reg [7:0] filt_prev_q;
  wire [7:0] filt;
  wire [15:0] param_word;
  wire cmd_ok;
  wire [2:0] sel;
  wire is_high_set;
  wire is_low_set;
  wire is_rval_set;
  // Commands with a nonzero reserved byte are dropped without reply
  assign cmd_ok = cmd_valid && (host_reserved_byte == `ICF_RESERVED_OK);
  assign param_word = {host_param_high_byte, host_param_low_byte};
  assign sel = host_command_byte[2:0];
  assign is_high_set = in_group(host_command_byte, `ICF_CMD_HIGH_BASE);
  assign is_low_set = in_group(host_command_byte, `ICF_CMD_LOW_BASE);
  assign is_rval_set = in_group(host_command_byte, `ICF_CMD_RVAL_BASE);

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : ch
      icf_filter u_filt (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick_q),
        .raw_level(stable_q[g]),
        .high_samples(high_samples_q[g]),
        .low_samples(low_samples_q[g]),
        .filtered_q(filt[g])
      );
    end
  endgenerate

  // =====================================================
  // Counters and command execution
  integer i;
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      edge_sel_q <= `ICF_EDGE_RESET;
      enable_q <= `ICF_ENABLE_RESET;
      filt_prev_q <= 8'h00;
      for (i = 0; i < 8; i = i + 1)
      begin
        high_samples_q[i] <= `ICF_SAMPLES_RESET;
        low_samples_q[i] <= `ICF_SAMPLES_RESET;
        reset_value_q[i] <= `ICF_COUNT_RESET;
        count_q[i] <= `ICF_COUNT_RESET;
      end
    end
    else
    begin
      filt_prev_q <= filt;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (enable_q[i] && edge_hit(edge_sel_q[i], filt_prev_q[i], filt[i]))
          count_q[i] <= count_q[i] + 16'h0001;
        // Written last so a reload wins over an edge in the same cycle
        if (cmd_ok && host_command_byte == `ICF_CMD_RELOAD && host_param_low_byte[i])
          count_q[i] <= reset_value_q[i];
      end
      if (cmd_ok)
      begin
        if (host_command_byte == `ICF_CMD_EDGE)
          edge_sel_q <= host_param_low_byte;
        if (host_command_byte == `ICF_CMD_ENABLE)
          enable_q <= host_param_low_byte;
        if (is_high_set)
          high_samples_q[sel] <= param_word;
        if (is_low_set)
          low_samples_q[sel] <= param_word;
        if (is_rval_set && enable_q[sel])
          reset_value_q[sel] <= param_word;
      end
    end
  end

  // =====================================================
  // Reply mailbox
  wire [15:0] read_val;
  // Upper bits of the channel field are ignored; host keeps them zero
  // Count is read before any effect of the same command
  assign read_val = count_q[host_param_low_byte[`ICF_CHAN_MSB:`ICF_CHAN_LSB]];
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reply_valid_q <= 1'b0;
      reply_low_byte_q <= 8'h00;
      reply_high_byte_q <= 8'h00;
      reply_echo_byte_q <= 8'h00;
      reply_input_levels_q <= 8'h00;
      filtered_levels_q <= 8'h00;
    end
    else
    begin
      reply_valid_q <= cmd_ok;
      filtered_levels_q <= filt;
      if (cmd_ok)
      begin
        reply_input_levels_q <= stable_q;
        reply_echo_byte_q <= host_command_byte;
        reply_low_byte_q <= 8'h00;
        reply_high_byte_q <= 8'h00;
        if (host_command_byte == `ICF_CMD_READ)
        begin
          reply_high_byte_q <= read_val[15:8];
          reply_low_byte_q <= read_val[7:0];
        end
      end
    end
  end
endmodule // icf_counter_block

// *** icf_counter_checker.sv ***
// Port assertions for the input counter block
`timescale 1ns/10ps
module icf_counter_checker #(
  parameter TICK_CYCLES = 4
) (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] isolated_input,
  input wire cmd_valid,
  input wire [7:0] host_command_byte,
  input wire [7:0] host_reserved_byte,
  input wire reply_valid_q,
  input wire [7:0] reply_low_byte_q,
  input wire [7:0] reply_high_byte_q,
  input wire [7:0] reply_echo_byte_q,
  input wire [7:0] reply_input_levels_q,
  input wire [7:0] filtered_levels_q
);
  // ==========
  // Helpers
  wire acc = cmd_valid && host_reserved_byte == 8'h00;
  reg [7:0] prev_q;
  reg [5:0] stab_q;
  // Counts quiet input cycles so sync latency never trips the level checks
  always @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      prev_q <= 8'h00;
      stab_q <= 6'h00;
    end
    else
    begin
      prev_q <= isolated_input;
      stab_q <= (isolated_input != prev_q) ? 6'h00 : stab_q + {5'h00, stab_q != 6'h3f};
    end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_reply; acc |=> reply_valid_q; endproperty
  a_reply: assert property (p_reply) else $error("no reply");
  property p_quiet; !acc |=> !reply_valid_q; endproperty
  a_quiet: assert property (p_quiet) else $error("stray reply");
  property p_echo; acc |=> reply_echo_byte_q == $past(host_command_byte); endproperty
  a_echo: assert property (p_echo) else $error("bad echo");
  property p_lvl; acc && stab_q > 6'h08 |=> reply_input_levels_q == $past(isolated_input); endproperty
  a_lvl: assert property (p_lvl) else $error("bad levels");
  property p_zero; acc && host_command_byte != 8'h2f |=> {reply_high_byte_q, reply_low_byte_q} == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("data not zero");
  property p_hold; !reply_valid_q |-> $stable(reply_echo_byte_q) && $stable(reply_low_byte_q); endproperty
  a_hold: assert property (p_hold) else $error("reply moved");
  property p_gap; $changed(filtered_levels_q) && TICK_CYCLES > 3 |=> $stable(filtered_levels_q)[*3]; endproperty
  a_gap: assert property (p_gap) else $error("filter off tick");
  property p_dir; $changed(filtered_levels_q) && stab_q > 6'h08 |->
    ((filtered_levels_q ^ $past(filtered_levels_q)) & (filtered_levels_q ^ isolated_input)) == 8'h00; endproperty
  a_dir: assert property (p_dir) else $error("filter moved wrong way");
  c_read: cover property (acc && host_command_byte == 8'h2f);
  c_refuse: cover property (cmd_valid && host_reserved_byte != 8'h00);
  c_filt: cover property ($rose(filtered_levels_q[0]));
endmodule // icf_counter_checker
bind icf_counter_block icf_counter_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock(clock),
  .sys_rst(sys_rst), .isolated_input(isolated_input), .cmd_valid(cmd_valid),
  .host_command_byte(host_command_byte), .host_reserved_byte(host_reserved_byte),
  .reply_valid_q(reply_valid_q), .reply_low_byte_q(reply_low_byte_q),
  .reply_high_byte_q(reply_high_byte_q), .reply_echo_byte_q(reply_echo_byte_q),
  .reply_input_levels_q(reply_input_levels_q), .filtered_levels_q(filtered_levels_q));

// *** tb_top.sv ***
// Self-checking bench for the input counter block
`timescale 1ns/10ps
module tb_top;
  reg clock, sys_rst, cmd_valid;
  reg [7:0] isolated_input, lo, hi, cmd_b, rsv, e, p;
  wire rv_q;
  wire [7:0] r_lo, r_hi, r_echo, r_lvl, filt;
  reg [15:0] rv [0:7];
  integer n_errors = 0, checks = 0, cyc = 0, i;
  // Short tick keeps filter waits to tens of cycles
  icf_counter_block #(.TICK_CYCLES(4)) DUT (.clock(clock), .sys_rst(sys_rst),
    .isolated_input(isolated_input), .cmd_valid(cmd_valid), .host_param_low_byte(lo),
    .host_param_high_byte(hi), .host_command_byte(cmd_b), .host_reserved_byte(rsv),
    .reply_valid_q(rv_q), .reply_low_byte_q(r_lo), .reply_high_byte_q(r_hi),
    .reply_echo_byte_q(r_echo), .reply_input_levels_q(r_lvl), .filtered_levels_q(filt));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==========
  // Tasks
  task chk(input string s, input [15:0] x, input [15:0] g);
    checks = checks + 1;
    if (g !== x)
    begin
      n_errors = n_errors + 1;
      $display("unexpected %s exp %h got %h", s, x, g);
    end
  endtask
  // Rising edges count where fall_sel is clear, falling ones once the level has dropped
  function automatic [15:0] exp_count(input [15:0] base, input rose, input fall_sel, input fell);
    exp_count = base + {15'h0000, rose & (fell | ~fall_sel)};
  endfunction
  task complete_run;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cmd(input [7:0] c, input [7:0] h, input [7:0] l, input [7:0] r);
    @(posedge clock);
    {cmd_valid, cmd_b, hi, lo, rsv} <= {1'b1, c, h, l, r};
    @(posedge clock);
    cmd_valid <= 1'b0;
    #1;
    chk("valid", r == 8'h00, rv_q);
    if (r == 8'h00)
    begin
      chk("echo", c, r_echo);
      chk("levels", isolated_input, r_lvl);
    end
  endtask
  task rd(input [2:0] n, input [15:0] x);
    cmd(8'h2f, 8'h00, {5'h00, n}, 8'h00);
    chk("count", x, {r_hi, r_lo});
  endtask
  task drv(input [7:0] v, input integer n);
    @(posedge clock);
    isolated_input <= v;
    repeat (n) @(posedge clock);
    #1;
  endtask
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    {sys_rst, cmd_valid, isolated_input, lo, hi, cmd_b, rsv} = {1'b1, 41'h0};
    void'($urandom(75759));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    e = $urandom;
    cmd(8'h28, 8'h00, 8'hff, 8'h00);
    cmd(8'h2c, 8'h00, e, 8'h00);
    for (i = 0; i < 8; i = i + 1)
    begin
      rv[i] = $urandom;
      cmd(8'h30 + i, 8'h00, 8'h02 + $urandom % 2, 8'h00);
      cmd(8'h38 + i, 8'h00, 8'h02, 8'h00);
      cmd(8'h40 + i, rv[i][15:8], rv[i][7:0], 8'h00);
    end
    cmd(8'h29, 8'h00, 8'hff, 8'h00);
    p = $urandom | 32'h1;
    drv(p, 3);
    drv(8'h00, 30);
    chk("glitch", 16'h0000, filt);
    drv(p, 40);
    chk("filter", p, filt);
    for (i = 0; i < 8; i = i + 1)
      rd(i, exp_count(rv[i], p[i], e[i], 1'b0));
    drv(8'h00, 40);
    for (i = 0; i < 8; i = i + 1)
      rd(i, exp_count(rv[i], p[i], e[i], 1'b1));
    cmd(8'h28, 8'h00, 8'h7f, 8'h00);
    cmd(8'h47, 8'h12, 8'h34, 8'h00);
    cmd(8'h28, 8'h00, 8'hff, 8'h00);
    cmd(8'h29, 8'h00, 8'h80, 8'h00);
    rd(7, rv[7]);
    cmd(8'h47, 8'h12, 8'h34, 8'h00);
    cmd(8'h29, 8'h00, 8'h80, 8'h00);
    rd(7, 16'h1234);
    // Long low count on channel 0 only, given through the high parameter byte
    cmd(8'h38, 8'h01, 8'h00, 8'h00);
    drv(8'hff, 40);
    chk("filter high", 16'h00ff, filt);
    drv(8'h00, 40);
    chk("filter low", 16'h0001, filt);
    cmd(8'h2f, 8'h00, 8'h00, 8'h01);
    complete_run;
  end
endmodule // tb_top
